// ==== design/bscan_regs_pkg.sv ====
// package for the boundary-scan test data registers
// assumes the tap controller and instruction register sit outside
package bscan_regs_pkg;

  // ************************************************************
  // instruction encodings
  // ************************************************************
  localparam int          INSTR_W        = 3;
  localparam logic [2:0]  INSTR_EXTEST   = 3'h0;
  localparam logic [2:0]  INSTR_IDCODE   = 3'h1;
  localparam logic [2:0]  INSTR_SAMPLE   = 3'h2;
  localparam logic [2:0]  INSTR_CLAMP    = 3'h3;
  localparam logic [2:0]  INSTR_HIGHZ    = 3'h4;
  localparam logic [2:0]  INSTR_BYPASS   = 3'h7;

  // ************************************************************
  // identification layout
  // ************************************************************
  localparam int          ID_W           = 32;
  localparam int          ID_MARK_POS    = 0;
  localparam int          ID_MFR_LSB     = 1;
  localparam int          ID_MFR_W       = 11;
  localparam int          ID_DEV_LSB     = 12;
  localparam int          ID_DEV_W       = 16;
  localparam int          ID_REV_LSB     = 28;
  localparam int          ID_REV_W       = 4;
  localparam logic        ID_MARK        = 1'b1;

  // ************************************************************
  // reset values and timing
  // ************************************************************
  localparam logic        BYPASS_RST     = 1'b0;
  localparam int          SYNC_STAGES    = 2;

  // tap controller state seen at the port
  typedef struct packed {
    logic tlr;
    logic capture_dr;
    logic shift_dr;
    logic update_dr;
  } tap_state_t;

  // serial link pins
  typedef struct packed {
    logic mode_select;
    logic serial_in;
  } link_in_t;

endpackage

// ==== design/bscan_test_regs.sv ====
// boundary-scan test data registers: bypass, boundary, identification
// assumes an outside tap controller on the test clock and a 125 mhz core
// What this block does
// - provides bypass and boundary registers plus an identification register
// - bypass, clamp and highz select a one-stage path in to out
// - boundary register has shift chain and separate latched outputs
// - identification register is 32 shift stages with a 32-bit latched stage that drives no port
// - identification selected under idcode and in test-logic-reset
// - id value is revision, device, manufacturer fields and marker one
// - instruction codes are three bits: 111,001,010,000,011,100
// - under idcode, capture-dr loads the id value, shift-dr shifts it
`timescale 1ns/1ns
module bscan_test_regs #(
  parameter int              BSR_W   = 16,
  parameter logic [3:0]      ID_REV  = 4'h0,    // arbitrary value
  parameter logic [15:0]     ID_DEV  = 16'h0001, // arbitrary value
  parameter logic [10:0]     ID_MFR  = 11'h001  // arbitrary value
) (
  // core clock domain
  input  wire logic                       i_clk,
  input  wire logic                       i_rst,
  input  wire logic [BSR_W-1:0]           i_core_sample,
  output logic      [BSR_W-1:0]           o_core_parallel,
  output logic                            o_core_drive,
  output logic                            o_core_highz,
  // test clock domain
  input  wire logic                       i_test_port_clock,
  input  wire logic                       i_test_rst,
  input  wire logic                       i_test_serial_in,
  input  wire logic [2:0]                 i_instr,
  input  wire bscan_regs_pkg::tap_state_t i_tap,
  output logic                            o_test_serial_out
);

  initial begin
    if (BSR_W < 1) $error("boundary width must be positive");
  end

  // ************************************************************
  // decode
  // ************************************************************
  logic sel_id;
  logic sel_bsr;
  logic sel_byp;
  always_comb begin
    sel_id  = i_tap.tlr || (i_instr == bscan_regs_pkg::INSTR_IDCODE);
    sel_bsr = !sel_id &&
              (i_instr == bscan_regs_pkg::INSTR_EXTEST ||
               i_instr == bscan_regs_pkg::INSTR_SAMPLE);
    sel_byp = !sel_id && !sel_bsr;
  end

  logic [31:0] id_value;
  assign id_value = {ID_REV, ID_DEV, ID_MFR, bscan_regs_pkg::ID_MARK};

  // ************************************************************
  // sample crossing into the test clock domain
  // ************************************************************
  logic [BSR_W-1:0] smp_s1_q;
  logic [BSR_W-1:0] smp_s2_q;
  always_ff @(posedge i_test_port_clock) begin
    smp_s1_q <= i_core_sample;
    smp_s2_q <= smp_s1_q;
  end

  // ************************************************************
  // shift registers on the test clock
  // ************************************************************
  logic             byp_q,  byp_d;
  logic [BSR_W-1:0] bsr_q,  bsr_d;
  logic [31:0]      id_q,   id_d;
  always_comb begin
    byp_d = byp_q;
    bsr_d = bsr_q;
    id_d  = id_q;
    if (i_tap.capture_dr) begin
      byp_d = 1'b0;
      if (sel_bsr) bsr_d = smp_s2_q;
      if (sel_id)  id_d  = id_value;
    end else if (i_tap.shift_dr) begin
      if (sel_byp) byp_d = i_test_serial_in;
      if (sel_bsr) bsr_d = {i_test_serial_in, bsr_q[BSR_W-1:1]};
      if (sel_id)  id_d  = {i_test_serial_in, id_q[31:1]};
    end
  end

  always_ff @(posedge i_test_port_clock) begin
    if (i_test_rst) begin
      byp_q <= bscan_regs_pkg::BYPASS_RST;
      bsr_q <= '0;
      id_q  <= '0;
    end else begin
      byp_q <= byp_d;
      bsr_q <= bsr_d;
      id_q  <= id_d;
    end
  end

  // ************************************************************
  // latched parallel stages, updated on falling test clock
  // ************************************************************
  logic [BSR_W-1:0] bsr_lat_q, bsr_lat_d;
  logic [31:0]      id_lat_q,  id_lat_d;
  always_comb begin
    bsr_lat_d = bsr_lat_q;
    id_lat_d  = id_lat_q;
    if (i_tap.update_dr && sel_bsr) bsr_lat_d = bsr_q;
    if (i_tap.update_dr && sel_id)  id_lat_d  = id_q;
  end
  always_ff @(negedge i_test_port_clock) begin
    if (i_test_rst) begin
      bsr_lat_q <= '0;
      id_lat_q  <= '0;
    end else begin
      bsr_lat_q <= bsr_lat_d;
      id_lat_q  <= id_lat_d;
    end
  end

  // serial out updates on falling edge, as usual for scan ports
  logic tdo_q, tdo_d;
  always_comb begin
    tdo_d = byp_q;
    if (sel_id)       tdo_d = id_q[0];
    else if (sel_bsr) tdo_d = bsr_q[0];
  end
  always_ff @(negedge i_test_port_clock) begin
    if (i_test_rst) tdo_q <= 1'b0;
    else            tdo_q <= tdo_d;
  end
  assign o_test_serial_out = tdo_q;

  // ************************************************************
  // core-side crossing of mode and parallel data
  // ************************************************************
  // latched data is stable while mode holds, so three flops and a compare suffice
  logic             drv_tq, hz_tq;
  always_ff @(posedge i_test_port_clock) begin
    if (i_test_rst) begin
      drv_tq <= 1'b0;
      hz_tq  <= 1'b0;
    end else begin
      drv_tq <= (i_instr == bscan_regs_pkg::INSTR_EXTEST ||
                 i_instr == bscan_regs_pkg::INSTR_CLAMP) && !i_tap.tlr;
      hz_tq  <= (i_instr == bscan_regs_pkg::INSTR_HIGHZ) && !i_tap.tlr;
    end
  end

  logic [BSR_W+1:0] cx_s1_q, cx_s2_q, cx_s3_q, cx_d;
  logic [BSR_W-1:0] par_q;
  logic             drv_q, hz_q;
  assign cx_d = {drv_tq, hz_tq, bsr_lat_q};
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cx_s1_q <= '0;
      cx_s2_q <= '0;
      cx_s3_q <= '0;
      par_q   <= '0;
      drv_q   <= 1'b0;
      hz_q    <= 1'b0;
    end else begin
      cx_s1_q <= cx_d;
      cx_s2_q <= cx_s1_q;
      cx_s3_q <= cx_s2_q;
      // take the word only once two samples agree, so a
      // half-changed word never reaches the pins
      if (cx_s2_q == cx_s3_q) begin
        par_q <= cx_s2_q[BSR_W-1:0];
        hz_q  <= cx_s2_q[BSR_W];
        drv_q <= cx_s2_q[BSR_W+1];
      end
    end
  end
  assign o_core_parallel = par_q;
  assign o_core_drive    = drv_q;
  assign o_core_highz    = hz_q;

  // ************************************************************
  // checks
  // ************************************************************
  chk_id_capture: assert property (@(posedge i_test_port_clock)
    disable iff (i_test_rst)
    (i_tap.capture_dr && sel_id) |=> (id_q == id_value))
    else $error("id value not captured");

  chk_id_marker: assert property (@(posedge i_test_port_clock)
    disable iff (i_test_rst)
    (i_tap.capture_dr && sel_id) |=> (id_q[0] == 1'b1))
    else $error("marker bit not one");

  chk_id_shift: assert property (@(posedge i_test_port_clock)
    disable iff (i_test_rst)
    (i_tap.shift_dr && sel_id) |=>
      (id_q[30:0] == $past(id_q[31:1])) && (id_q[31] == $past(i_test_serial_in)))
    else $error("id shift wrong");

  chk_tlr_select: assert property (@(posedge i_test_port_clock)
    disable iff (i_test_rst)
    i_tap.tlr |-> sel_id)
    else $error("id not selected in reset state");

  chk_bypass_path: assert property (@(posedge i_test_port_clock)
    disable iff (i_test_rst)
    (i_tap.shift_dr && i_instr == bscan_regs_pkg::INSTR_BYPASS && !i_tap.tlr)
      |=> (byp_q == $past(i_test_serial_in)))
    else $error("bypass stage wrong");

  chk_bypass_capture: assert property (@(posedge i_test_port_clock)
    disable iff (i_test_rst)
    (i_tap.capture_dr && sel_byp) |=> !byp_q)
    else $error("bypass capture not zero");

  chk_bsr_shift: assert property (@(posedge i_test_port_clock)
    disable iff (i_test_rst)
    (i_tap.shift_dr && i_instr == bscan_regs_pkg::INSTR_SAMPLE && !i_tap.tlr)
      |=> (bsr_q[BSR_W-1] == $past(i_test_serial_in)))
    else $error("boundary shift wrong");

  chk_code_decode: assert property (@(posedge i_test_port_clock)
    disable iff (i_test_rst)
    (!i_tap.tlr && i_instr == bscan_regs_pkg::INSTR_HIGHZ) |-> sel_byp)
    else $error("highz not on bypass");

  chk_lsb_first: assert property (@(posedge i_test_port_clock)
    disable iff (i_test_rst)
    (i_tap.capture_dr && sel_id) ##1 (sel_id && !i_tap.capture_dr)
      |-> ##[0:1] (o_test_serial_out == 1'b1))
    else $error("marker not first out");

  chk_bsr_capture: assert property (@(posedge i_test_port_clock)
    disable iff (i_test_rst)
    (i_tap.capture_dr && sel_bsr) |=> (bsr_q == $past(smp_s2_q)))
    else $error("boundary capture wrong");

  chk_id_hold: assert property (@(posedge i_test_port_clock)
    disable iff (i_test_rst)
    !((i_tap.capture_dr || i_tap.shift_dr) && sel_id)
      |=> (id_q == $past(id_q)))
    else $error("id register moved while unselected");

  chk_bsr_hold: assert property (@(posedge i_test_port_clock)
    disable iff (i_test_rst)
    !((i_tap.capture_dr || i_tap.shift_dr) && sel_bsr)
      |=> (bsr_q == $past(bsr_q)))
    else $error("boundary register moved while unselected");

  chk_byp_hold: assert property (@(posedge i_test_port_clock)
    disable iff (i_test_rst)
    (!i_tap.capture_dr && !(i_tap.shift_dr && sel_byp))
      |=> (byp_q == $past(byp_q)))
    else $error("bypass stage moved while unselected");

  chk_bsr_latch: assert property (@(posedge i_test_port_clock)
    disable iff (i_test_rst)
    (i_tap.update_dr && sel_bsr) |=> (bsr_lat_q == $past(bsr_q)))
    else $error("boundary latch not updated");

  chk_id_latch: assert property (@(posedge i_test_port_clock)
    disable iff (i_test_rst)
    (i_tap.update_dr && sel_id) |=> (id_lat_q == $past(id_q)))
    else $error("id latch not updated");

  chk_bsr_lat_hold: assert property (@(posedge i_test_port_clock)
    disable iff (i_test_rst)
    !i_tap.update_dr |-> (bsr_lat_q == $past(bsr_lat_q)))
    else $error("boundary latch moved outside update");

  chk_id_lat_hold: assert property (@(posedge i_test_port_clock)
    disable iff (i_test_rst)
    !i_tap.update_dr |-> (id_lat_q == $past(id_lat_q)))
    else $error("id latch moved outside update");

  chk_byp_out: assert property (@(posedge i_test_port_clock)
    disable iff (i_test_rst)
    sel_byp |-> (o_test_serial_out == byp_q))
    else $error("bypass stage not on serial out");

  chk_idcode_select: assert property (@(posedge i_test_port_clock)
    disable iff (i_test_rst)
    (i_instr == bscan_regs_pkg::INSTR_IDCODE) |-> sel_id)
    else $error("id not selected under idcode");

  chk_bsr_select: assert property (@(posedge i_test_port_clock)
    disable iff (i_test_rst)
    (!i_tap.tlr && (i_instr == bscan_regs_pkg::INSTR_SAMPLE ||
                    i_instr == bscan_regs_pkg::INSTR_EXTEST)) |-> sel_bsr)
    else $error("boundary not selected");

  chk_clamp_bypass: assert property (@(posedge i_test_port_clock)
    disable iff (i_test_rst)
    (!i_tap.tlr && i_instr == bscan_regs_pkg::INSTR_CLAMP) |-> sel_byp)
    else $error("clamp not on bypass");

  chk_one_select: assert property (@(posedge i_test_port_clock)
    disable iff (i_test_rst)
    $onehot({sel_id, sel_bsr, sel_byp}))
    else $error("not exactly one register selected");

  // core side: outputs quiet after reset, never drive and float at once
  chk_core_reset: assert property (@(posedge i_clk)
    i_rst |=> (!o_core_drive && !o_core_highz && o_core_parallel == '0))
    else $error("core outputs not cleared by reset");

  chk_drive_highz: assert property (@(posedge i_clk)
    disable iff (i_rst)
    !(o_core_drive && o_core_highz))
    else $error("drive and highz together");

endmodule // bscan_test_regs

// ==== tb/scan_host.sv ====
// test controller model: drives tap state, instruction and serial in
// assumes the block samples on rising and drives out on falling edge
`timescale 1ns/1ns
module scan_host (
  // test port
  output logic                       o_tck,
  output logic                       o_rst,
  output logic                       o_sdi,
  output logic [2:0]                 o_instr,
  output bscan_regs_pkg::tap_state_t o_tap,
  input  wire logic                  i_sdo
);
  // ****************
  // clock and frames
  // ****************
  logic en = 1'b0;
  initial begin
    o_tck = 1'b0;
    o_rst = 1'b1;
    o_sdi = 1'b0;
    o_instr = 3'h7;
    o_tap = 4'h0;
  end
  // clock parked low between frames
  always #15 o_tck = en ? ~o_tck : 1'b0;

  task automatic reset_port();
    en = 1'b1;
    o_rst <= 1'b1;
    repeat (3) @(posedge o_tck);
    o_rst <= 1'b0;
    @(posedge o_tck);
    en = 1'b0;
  endtask

  // hold test-logic-reset with bypass current and read the out pin
  task automatic tlr_peek(output logic b);
    en = 1'b1;
    @(posedge o_tck);
    o_instr <= 3'h7;
    o_tap <= 4'h8;
    @(posedge o_tck);
    b = i_sdo;
    o_tap <= 4'h0;
    repeat (2) @(posedge o_tck);
    en = 1'b0;
  endtask

  // capture, n shifts, exit, update, idle
  task automatic scan(input logic [2:0] ins, input int n,
                      input logic [35:0] din, output logic [35:0] dout);
    dout = '0;
    en = 1'b1;
    @(posedge o_tck);
    o_instr <= ins;
    o_tap <= 4'h4;
    @(posedge o_tck);
    o_tap <= 4'h2;
    o_sdi <= din[0];
    for (int i = 0; i < n; i++) begin
      @(posedge o_tck);
      dout[i] = i_sdo;
      o_sdi <= din[(i + 1) % 36];
      if (i == n - 1) o_tap <= 4'h0;
    end
    @(posedge o_tck);
    o_tap <= 4'h1;
    @(posedge o_tck);
    o_tap <= 4'h0;
    // released data line shows the inverse, not the last bit
    o_sdi <= ~din[n % 36];
    repeat (2) @(posedge o_tck);
    en = 1'b0;
  endtask
endmodule // scan_host

// ==== tb/test_bscan_test_regs.sv ====
// self-checking bench for the boundary-scan test data registers
// assumes scan_host plays the outside test controller
`timescale 1ns/1ns
module test_bscan_test_regs;
  typedef struct packed {
    logic [2:0]  ins;
    logic [5:0]  len;
    logic [31:0] cap;
    logic        drv;
    logic        hz;
  } row_t;
  localparam logic [31:0] ID   = {4'h3, 16'h00a5, 11'h05c, 1'b1};
  localparam logic [15:0] SAMP = 16'h5a3c;
  localparam logic [35:0] DIN  = 36'h93c5aa5c3;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [15:0] samp = '0;
  logic        tck, trst, sdi, sdo, drv, hz;
  logic [2:0]  instr;
  logic [15:0] par, pexp;
  logic [35:0] got, exp;
  bscan_regs_pkg::tap_state_t tap;
  int          fails = 0;
  int          n_compared = 0;
  int          cycles = 0;
  int          n;
  logic        tlr_bit;
  row_t rows [7] = '{
    '{3'h1, 6'd32, ID, 1'b0, 1'b0},
    '{3'h7, 6'd1, 32'h0, 1'b0, 1'b0},
    '{3'h2, 6'd16, {16'h0, SAMP}, 1'b0, 1'b0},
    '{3'h0, 6'd16, {16'h0, SAMP}, 1'b1, 1'b0},
    '{3'h3, 6'd1, 32'h0, 1'b1, 1'b0},
    '{3'h4, 6'd1, 32'h0, 1'b0, 1'b1},
    '{3'h5, 6'd1, 32'h0, 1'b0, 1'b0}};

  always #4 clk = ~clk;

  bscan_test_regs #(.BSR_W(16), .ID_REV(4'h3), .ID_DEV(16'h00a5),
                    .ID_MFR(11'h05c)) u_dut (
    .i_clk(clk), .i_rst(rst), .i_core_sample(samp),
    .o_core_parallel(par), .o_core_drive(drv), .o_core_highz(hz),
    .i_test_port_clock(tck), .i_test_rst(trst), .i_test_serial_in(sdi),
    .i_instr(instr), .i_tap(tap), .o_test_serial_out(sdo));

  scan_host u_host (.o_tck(tck), .o_rst(trst), .o_sdi(sdi),
                    .o_instr(instr), .o_tap(tap), .i_sdo(sdo));

  // ****************
  // checks and end
  // ****************
  task automatic stop_test();
    $display("compared %0d, failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic cmp_stream(input logic [35:0] g, e);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("FAIL %0t serial %h expected %h", $time, g, e);
    end
  endtask

  task automatic cmp_core(input logic [15:0] gp, ep,
                          input logic gd, ed, gh, eh);
    n_compared++;
    if ({gp, gd, gh} !== {ep, ed, eh}) begin
      fails++;
      $display("FAIL %0t core %h %b %b", $time, gp, gd, gh);
    end
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      stop_test();
    end
  end

  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    samp <= SAMP;
    u_host.reset_port();
    pexp = '0;
    repeat (8) @(posedge clk);
    cmp_core(par, 16'h0, drv, 1'b0, hz, 1'b0);
    for (int r = 0; r < 7; r++) begin
      n = rows[r].len + 4;
      u_host.scan(rows[r].ins, n, DIN, got);
      exp = '0;
      for (int i = 0; i < n; i++) begin
        if (i < rows[r].len) exp[i] = rows[r].cap[i];
        else exp[i] = DIN[i - rows[r].len];
      end
      // boundary update latches the last sixteen bits shifted in
      if (rows[r].len == 6'd16) pexp = DIN[19:4];
      repeat (8) @(posedge clk);
      cmp_stream(got, exp);
      cmp_core(par, pexp, drv, rows[r].drv, hz, rows[r].hz);
    end
    // test-logic-reset selects the id register whatever the code
    u_host.scan(3'h1, 3, DIN, got);
    cmp_stream({33'h0, got[2:0]}, {33'h0, ID[2:0]});
    u_host.tlr_peek(tlr_bit);
    cmp_stream({35'h0, tlr_bit}, {35'h0, ID[3]});
    // test reset in mid-run clears the latched outputs
    u_host.reset_port();
    repeat (8) @(posedge clk);
    cmp_core(par, 16'h0, drv, 1'b0, hz, 1'b0);
    stop_test();
  end
endmodule // test_bscan_test_regs
